// [core/tcr_pkg.sv]
/*
  Constants, mode classes and the state record of the timer control block.
  Assumes a single 100 MHz clock domain and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package tcr_pkg;
  // Byte offsets on the register bus.
  localparam logic [7:0]  OFF_CTRL_A  = 8'h00;
  localparam logic [7:0]  OFF_CTRL_B  = 8'h04;
  localparam logic [7:0]  OFF_CTRL_C  = 8'h08;
  localparam logic [7:0]  OFF_COUNT   = 8'h0c;
  localparam logic [7:0]  OFF_MATCH_A = 8'h10;
  localparam logic [7:0]  OFF_MATCH_B = 8'h14;
  localparam logic [7:0]  OFF_MATCH_C = 8'h18;
  localparam logic [7:0]  OFF_CAPTURE = 8'h1c;
  localparam logic [7:0]  OFF_FLAGS   = 8'h20;
  // Field positions.
  localparam int          ACT_A_POS   = 6;
  localparam int          WGM_LO_POS  = 0;
  localparam int          FILT_POS    = 7;
  localparam int          EDGE_POS    = 6;
  localparam int          WGM_HI_POS  = 3;
  localparam int          CS_POS      = 0;
  localparam int          FORCE_A_POS = 7;
  localparam int          FLG_OVF     = 0;
  localparam int          FLG_CAP     = 1;
  localparam int          FLG_MATCH_A = 2;
  // Reset values and masks.
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_B_MASK = 8'hdf;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  // Counter limits.
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [15:0] TOP_8BIT    = 16'h00ff;
  localparam logic [15:0] TOP_9BIT    = 16'h01ff;
  localparam logic [15:0] TOP_10BIT   = 16'h03ff;
  // Prescaler taps as log2 of the division, and clock select codes.
  localparam int          PRE_LOG8    = 3;
  localparam int          PRE_LOG64   = 6;
  localparam int          PRE_LOG256  = 8;
  localparam int          PRE_LOG1024 = 10;
  localparam logic [2:0]  CS_STOP     = 3'h0;
  localparam logic [2:0]  CS_DIV1     = 3'h1;
  localparam logic [2:0]  CS_DIV8     = 3'h2;
  localparam logic [2:0]  CS_DIV64    = 3'h3;
  localparam logic [2:0]  CS_DIV256   = 3'h4;
  localparam logic [2:0]  CS_DIV1024  = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE = 3'h7;
  // Equal samples the capture filter needs before it follows the input.
  localparam int          FILT_SAMPLES = 4;

  typedef enum logic [4:0] {
    CLS_NORMAL = 5'b00001,
    CLS_CTC    = 5'b00010,
    CLS_FAST   = 5'b00100,
    CLS_PC     = 5'b01000,
    CLS_PFC    = 5'b10000
  } tcr_class_t;

  typedef struct packed {
    logic [7:0]                ctrl_a;
    logic [7:0]                ctrl_b;
    logic [15:0]               count;
    logic                      count_down;
    logic [2:0][15:0]          buf_match;
    logic [2:0][15:0]          act_match;
    logic [15:0]               capture;
    logic [4:0]                flags;
    logic [2:0]                wave;
    logic [2:0]                wave_oe;
    logic [PRE_LOG1024-1:0]    pre;
    logic [1:0]                ext_sync;
    logic                      ext_prev;
    logic [1:0]                cap_sync;
    logic [FILT_SAMPLES-2:0]   cap_hist;
    logic                      cap_filt;
    logic                      cap_prev;
    logic [7:0]                addr;
    logic                      wr;
    logic [31:0]               rdata;
    logic                      ready;
    logic                      resp;
  } tcr_state_t;
endpackage : tcr_pkg
`default_nettype wire

// [core/tcr_timer_ctrl.sv]
/*
  Control logic of a 16-bit timer with three compare channels and one
  capture unit, reached over AHB-Lite. Assumes one master that leaves a
  bus cycle idle during each data phase, and asynchronous pin inputs.
*/
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tcr_timer_ctrl
  import tcr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  wire logic        i_capture_input_pin,
  input  wire logic        i_external_count_pin,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_wave_out_a,
  output logic             o_wave_out_b,
  output logic             o_wave_out_c,
  output logic             o_wave_oe_a,
  output logic             o_wave_oe_b,
  output logic             o_wave_oe_c
);

  tcr_state_t  s_ff;
  tcr_state_t  nxt_s;
  logic [3:0]  wgm;
  tcr_class_t  cls;
  logic        pwm;
  logic        dual;
  logic [15:0] top;
  logic        at_top;
  logic        tick;
  logic        cap_in;
  logic        cap_evt;
  logic        ovf_evt;
  logic        upd;
  logic [2:0]  hit;
  logic [2:0]  force_w;
  logic        take;
  logic        addr_ok;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  function automatic tcr_class_t wgm_class(input logic [3:0] w);
    case (w)
      4'd1, 4'd2, 4'd3, 4'd10, 4'd11: wgm_class = CLS_PC;
      4'd4, 4'd12:                    wgm_class = CLS_CTC;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15: wgm_class = CLS_FAST;
      4'd8, 4'd9:                     wgm_class = CLS_PFC;
      default:                        wgm_class = CLS_NORMAL;
    endcase
  endfunction

  function automatic logic icr_is_top(input logic [3:0] w);
    icr_is_top = (w == 4'd8) || (w == 4'd10) || (w == 4'd12) || (w == 4'd14);
  endfunction

  function automatic logic [1:0] act_of(input logic [7:0] ca, input int ch);
    act_of = ca[ACT_A_POS-2*ch +: 2];
  endfunction

  function automatic logic wsel(input tcr_state_t s, input logic [7:0] off);
    wsel = s.wr && (s.addr == off);
  endfunction

  // Channel A may toggle in PWM modes only in modes 9 and 15.
  function automatic logic conn(input tcr_class_t c, input logic [3:0] w,
                                input logic [1:0] act, input int ch);
    if (act == 2'b00)
      conn = 1'b0;
    else if (act == 2'b01 && c == CLS_FAST)
      conn = (ch == 0) && (w == 4'd15);
    else if (act == 2'b01 && (c == CLS_PC || c == CLS_PFC))
      conn = (ch == 0) && (w == 4'd9 || w == 4'd14);
    else
      conn = 1'b1;
  endfunction

  function automatic logic wave_nx(input tcr_class_t c, input logic [1:0] act,
                                   input logic cur, input logic hm,
                                   input logic tp, input logic dn);
    wave_nx = cur;
    if (hm && act == 2'b01)
      wave_nx = ~cur;
    else if (hm && act[1])
      wave_nx = ((c == CLS_PC || c == CLS_PFC) && dn) ? ~act[0] : act[0];
    if (c == CLS_FAST && tp && act[1])
      wave_nx = ~act[0];
  endfunction

  function automatic logic [31:0] rd_word(input tcr_state_t s,
                                          input logic [7:0] a);
    case (a)
      OFF_CTRL_A:  rd_word = {24'h000000, s.ctrl_a};
      OFF_CTRL_B:  rd_word = {24'h000000, s.ctrl_b};
      OFF_COUNT:   rd_word = {16'h0000, s.count};
      OFF_MATCH_A: rd_word = {16'h0000, s.buf_match[0]};
      OFF_MATCH_B: rd_word = {16'h0000, s.buf_match[1]};
      OFF_MATCH_C: rd_word = {16'h0000, s.buf_match[2]};
      OFF_CAPTURE: rd_word = {16'h0000, s.capture};
      OFF_FLAGS:   rd_word = {27'h0000000, s.flags};
      default:     rd_word = 32'h00000000;
    endcase
  endfunction

  assign wgm = {s_ff.ctrl_b[WGM_HI_POS +: 2], s_ff.ctrl_a[WGM_LO_POS +: 2]};
  assign cls = wgm_class(wgm);
  assign pwm = (cls == CLS_FAST) || (cls == CLS_PC) || (cls == CLS_PFC);
  assign dual = (cls == CLS_PC) || (cls == CLS_PFC);

  always_comb
  begin
    case (wgm)
      4'd1, 4'd5:                top = TOP_8BIT;
      4'd2, 4'd6:                top = TOP_9BIT;
      4'd3, 4'd7:                top = TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15:  top = s_ff.act_match[0];
      4'd8, 4'd10, 4'd12, 4'd14: top = s_ff.capture;
      default:                   top = CNT_MAX;
    endcase
  end
  assign at_top = (s_ff.count == top);

  // Prescaler taps come from one free-running counter, so they stay in phase.
  always_comb
  begin
    case (s_ff.ctrl_b[CS_POS +: 3])
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = &s_ff.pre[PRE_LOG8-1:0];
      CS_DIV64:    tick = &s_ff.pre[PRE_LOG64-1:0];
      CS_DIV256:   tick = &s_ff.pre[PRE_LOG256-1:0];
      CS_DIV1024:  tick = &s_ff.pre[PRE_LOG1024-1:0];
      CS_EXT_FALL: tick = ~s_ff.ext_sync[1] & s_ff.ext_prev;
      CS_EXT_RISE: tick = s_ff.ext_sync[1] & ~s_ff.ext_prev;
      default:     tick = 1'b0;
    endcase
  end

  assign cap_in = s_ff.ctrl_b[FILT_POS] ? s_ff.cap_filt : s_ff.cap_sync[1];
  assign cap_evt = !icr_is_top(wgm) && (cap_in != s_ff.cap_prev)
                   && (cap_in == s_ff.ctrl_b[EDGE_POS]);
  assign ovf_evt = tick && ((!pwm && s_ff.count == CNT_MAX)
                   || (cls == CLS_FAST && at_top)
                   || (dual && s_ff.count_down && s_ff.count == CNT_BOTTOM));
  assign upd = !pwm || (tick && (((cls == CLS_FAST || cls == CLS_PC) && at_top)
               || (cls == CLS_PFC && s_ff.count == CNT_BOTTOM)));

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ch
      assign hit[g] = tick && (s_ff.count == s_ff.act_match[g])
                      && !(cls == CLS_FAST && s_ff.ctrl_a[ACT_A_POS+1-2*g]
                      && s_ff.act_match[g] == top);
      assign force_w[g] = wsel(s_ff, OFF_CTRL_C) && !pwm
                          && i_hwdata[FORCE_A_POS-g];
    end
  endgenerate

  assign take = i_hsel && i_htrans[1] && i_hready;
  assign addr_ok = (i_haddr[31:8] == 24'h000000) && (i_haddr[1:0] == 2'b00);

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.pre = s_ff.pre + 10'h001;
    nxt_s.ext_sync = {s_ff.ext_sync[0], i_external_count_pin};
    nxt_s.ext_prev = s_ff.ext_sync[1];
    nxt_s.cap_sync = {s_ff.cap_sync[0], i_capture_input_pin};
    nxt_s.cap_hist = {s_ff.cap_hist[FILT_SAMPLES-3:0], s_ff.cap_sync[1]};
    if (&{s_ff.cap_hist, s_ff.cap_sync[1]} || ~|{s_ff.cap_hist, s_ff.cap_sync[1]})
      nxt_s.cap_filt = s_ff.cap_sync[1];
    nxt_s.cap_prev = cap_in;
    if (!dual)
      nxt_s.count_down = 1'b0;
    if (tick && !dual)
      nxt_s.count = at_top ? CNT_BOTTOM : s_ff.count + 16'h0001;
    else if (tick && !s_ff.count_down)
    begin
      if (s_ff.count >= top && top != CNT_BOTTOM)
      begin
        nxt_s.count_down = 1'b1;
        nxt_s.count = s_ff.count - 16'h0001;
      end
      else
        nxt_s.count = s_ff.count + 16'h0001;
    end
    else if (tick)
    begin
      if (s_ff.count == CNT_BOTTOM)
      begin
        nxt_s.count_down = 1'b0;
        nxt_s.count = s_ff.count + 16'h0001;
      end
      else
        nxt_s.count = s_ff.count - 16'h0001;
    end
    if (upd)
      nxt_s.act_match = s_ff.buf_match;
    if (cap_evt)
      nxt_s.capture = s_ff.count;
    for (int i = 0; i < 3; i++)
    begin
      nxt_s.wave[i] = wave_nx(cls, act_of(s_ff.ctrl_a, i), s_ff.wave[i],
                              hit[i] | force_w[i], at_top && tick,
                              s_ff.count_down);
      nxt_s.wave_oe[i] = conn(cls, wgm, act_of(s_ff.ctrl_a, i), i);
    end
    // Data phase of a write; counter writes win over counting.
    if (s_ff.wr)
    begin
      case (s_ff.addr)
        OFF_CTRL_A:  nxt_s.ctrl_a = i_hwdata[7:0];
        OFF_CTRL_B:  nxt_s.ctrl_b = i_hwdata[7:0] & CTRL_B_MASK;
        OFF_COUNT:   nxt_s.count = i_hwdata[15:0];
        OFF_MATCH_A: nxt_s.buf_match[0] = i_hwdata[15:0];
        OFF_MATCH_B: nxt_s.buf_match[1] = i_hwdata[15:0];
        OFF_MATCH_C: nxt_s.buf_match[2] = i_hwdata[15:0];
        OFF_CAPTURE: nxt_s.capture = i_hwdata[15:0];
        default:     nxt_s.ctrl_a = s_ff.ctrl_a;
      endcase
    end
    // A flag raised in the clearing cycle survives, so no event is lost.
    nxt_s.flags = s_ff.flags & ~(wsel(s_ff, OFF_FLAGS) ? i_hwdata[4:0] : 5'h00);
    nxt_s.flags = nxt_s.flags | {hit, cap_evt, ovf_evt};
    nxt_s.wr = take && i_hwrite && addr_ok;
    nxt_s.addr = i_haddr[7:0];
    if (take && !i_hwrite)
      nxt_s.rdata = addr_ok ? rd_word(s_ff, i_haddr[7:0]) : 32'h00000000;
    nxt_s.ready = 1'b1;
    nxt_s.resp = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_ff <= '0;
      s_ff.ready <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign o_hrdata = s_ff.rdata;
  assign o_hreadyout = s_ff.ready;
  assign o_hresp = s_ff.resp;
  assign o_wave_out_a = s_ff.wave[0];
  assign o_wave_out_b = s_ff.wave[1];
  assign o_wave_out_c = s_ff.wave[2];
  assign o_wave_oe_a = s_ff.wave_oe[0];
  assign o_wave_oe_b = s_ff.wave_oe[1];
  assign o_wave_oe_c = s_ff.wave_oe[2];

  a_pin_connect: assert property (!pwm && act_of(s_ff.ctrl_a, 1) != 2'b00
    |=> o_wave_oe_b)
    else $error("channel B not connected with nonzero action");
  a_toggle_match: assert property (!pwm && act_of(s_ff.ctrl_a, 0) == 2'b01
    && hit[0] |=> o_wave_out_a != $past(o_wave_out_a))
    else $error("channel A did not toggle on match");
  a_fast_top_set: assert property (cls == CLS_FAST && tick && at_top
    && act_of(s_ff.ctrl_a, 1) == 2'b10 |=> o_wave_out_b)
    else $error("fast PWM did not set output at top");
  a_dual_up_clear: assert property (dual && !s_ff.count_down && hit[2] &&
    !at_top && act_of(s_ff.ctrl_a, 2) == 2'b10 |=> !o_wave_out_c)
    else $error("dual slope up match did not clear output");
  a_filter_hold: assert property (s_ff.ctrl_b[FILT_POS] &&
    !(&{s_ff.cap_hist, s_ff.cap_sync[1]}) && |{s_ff.cap_hist, s_ff.cap_sync[1]}
    |=> $stable(s_ff.cap_filt))
    else $error("capture filter changed without four equal samples");
  a_capture_copy: assert property (cap_evt && !s_ff.wr |=>
    s_ff.capture == $past(s_ff.count) && s_ff.flags[FLG_CAP])
    else $error("capture did not copy counter or set flag");
  a_capture_off: assert property (icr_is_top(wgm) && !s_ff.wr
    |=> s_ff.capture == $past(s_ff.capture))
    else $error("capture fired while capture value is top");
  a_ext_rise: assert property (s_ff.ctrl_b[CS_POS +: 3] == CS_EXT_RISE &&
    $rose(s_ff.ext_sync[1]) |-> tick)
    else $error("external rising edge did not count");
  a_force_quiet: assert property (force_w[0] && !hit[0] &&
    !s_ff.flags[FLG_MATCH_A] |=> !s_ff.flags[FLG_MATCH_A])
    else $error("forced match raised a flag");
  a_stop_count: assert property (s_ff.ctrl_b[CS_POS +: 3] == CS_STOP &&
    !s_ff.wr |=> $stable(s_ff.count))
    else $error("counter moved while stopped");

  c_capture: cover property (cap_evt);
  c_fast_top: cover property (cls == CLS_FAST && tick && at_top);
  c_dual_turn: cover property (dual && $rose(s_ff.count_down));
  c_force_ctc: cover property (cls == CLS_CTC && force_w[0]);

endmodule : tcr_timer_ctrl
`default_nettype wire

// [testbench/tcr_pin_model.sv]
/*
  Pin-side model: drives the capture and count pins and shows pad A.
  Assumes its tasks are called just after a rising edge of i_ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module tcr_pin_model (
  input  wire logic i_ref_clk,
  input  wire logic i_wave_a,
  input  wire logic i_oe_a,
  input  wire logic i_dir_a,
  output logic      o_cap_pin,
  output logic      o_ext_pin,
  output logic      o_pad_a
);
  // The pad has a pull-up, so an undriven pin reads high.
  assign o_pad_a = (i_oe_a && i_dir_a) ? i_wave_a : 1'b1;
  initial
  begin
    o_cap_pin = 1'b0;
    o_ext_pin = 1'b0;
  end
  // Each level lasts w cycles so the synchroniser sees every edge.
  task automatic ext_toggle(input int n, input int w);
    repeat (n)
    begin
      o_ext_pin <= ~o_ext_pin;
      repeat (w) @(posedge i_ref_clk);
    end
  endtask
  task automatic cap_set(input logic lv, input int hold);
    o_cap_pin <= lv;
    repeat (hold) @(posedge i_ref_clk);
  endtask
endmodule // tcr_pin_model
`default_nettype wire

// [testbench/test_timer16_control_regs.sv]
/*
  Self-checking bench of the timer control block.
  Assumes tcr_pin_model on the pins and one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_timer16_control_regs;
  import tcr_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [2:0]  wave;
  logic [2:0]  oe;
  logic        dir_a;
  logic        cap_pin;
  logic        ext_pin;
  logic        pad_a;
  int          error_cnt;
  int          check_count;

  tcr_timer_ctrl DUT (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .i_capture_input_pin(cap_pin),
    .i_external_count_pin(ext_pin), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_wave_out_a(wave[0]), .o_wave_out_b(wave[1]),
    .o_wave_out_c(wave[2]), .o_wave_oe_a(oe[0]), .o_wave_oe_b(oe[1]),
    .o_wave_oe_c(oe[2]));
  tcr_pin_model model (
    .i_ref_clk(ref_clk), .i_wave_a(wave[0]), .i_oe_a(oe[0]), .i_dir_a(dir_a),
    .o_cap_pin(cap_pin), .o_ext_pin(ext_pin), .o_pad_a(pad_a));

  always #5 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Every wait is left open; the watchdog alone cuts a hung handshake short.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask

  task automatic test_regs;
    logic [31:0] d;
    rd(OFF_CTRL_A, d);
    check("ctrl_a reset", d, {24'h0, CTRL_RESET});
    rd(OFF_CTRL_B, d);
    check("ctrl_b reset", d, {24'h0, CTRL_RESET});
    check("hresp okay", 32'(hresp), 32'h0);
    wr(OFF_CTRL_A, 32'hff);
    rd(OFF_CTRL_A, d);
    check("ctrl_a rw", d, 32'hff);
    wr(OFF_CTRL_B, 32'hd8);
    rd(OFF_CTRL_B, d);
    check("ctrl_b rw", d, {24'h0, 8'hd8 & CTRL_B_MASK});
    wr(OFF_CTRL_C, 32'he0);
    rd(OFF_CTRL_C, d);
    check("ctrl_c read", d, 32'h0);
    rd(8'h40, d);
    check("unmapped", d, 32'h0);
    wr(OFF_CTRL_A, 32'h0);
    wr(OFF_CTRL_B, 32'h0);
    $display("done regs");
  endtask

  // A span of two periods holds exactly two prescaled ticks; with CS_STOP it holds none.
  task automatic test_prescale;
    logic [2:0]  cs [6] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_STOP};
    int          dv [6] = '{1, 8, 64, 256, 1024, 4};
    logic [31:0] a;
    logic [31:0] b;
    for (int i = 0; i < 6; i++)
    begin
      wr(OFF_CTRL_B, {29'h0, cs[i]});
      rd(OFF_COUNT, a);
      repeat (2 * dv[i] - 2) @(posedge ref_clk);
      rd(OFF_COUNT, b);
      check("count step", (b - a) & 32'hffff, (i == 5) ? 32'h0 : 32'h2);
    end
    $display("done prescale");
  endtask

  task automatic test_ext;
    logic [31:0] a;
    logic [31:0] b;
    wr(OFF_CTRL_B, {29'h0, CS_EXT_RISE});
    rd(OFF_COUNT, a);
    model.ext_toggle(5, 6);
    rd(OFF_COUNT, b);
    check("rise count", b - a, 32'h3);
    wr(OFF_CTRL_B, {29'h0, CS_EXT_FALL});
    rd(OFF_COUNT, a);
    model.ext_toggle(4, 6);
    rd(OFF_COUNT, b);
    check("fall count", b - a, 32'h2);
    $display("done ext");
  endtask

  task automatic test_force;
    logic [1:0]  act [6] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h2};
    logic        ew [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [31:0] d;
    wr(OFF_CTRL_B, 32'h0);
    wr(OFF_COUNT, 32'h0100);
    wr(OFF_FLAGS, 32'h1f);
    for (int ch = 0; ch < 3; ch++)
    begin
      for (int k = 0; k < 6; k++)
      begin
        wr(OFF_CTRL_A, 32'(act[k]) << (ACT_A_POS - 2 * ch));
        wr(OFF_CTRL_C, 32'h80 >> ch);
        repeat (2) @(posedge ref_clk);
        check("wave", 32'(wave[ch]), 32'(ew[k]));
        check("oe", 32'(oe[ch]), 32'h1);
      end
    end
    rd(OFF_FLAGS, d);
    check("force flags", d, 32'h0);
    wr(OFF_CTRL_B, 32'h08);
    wr(OFF_CTRL_A, 32'hc0);
    repeat (2) @(posedge ref_clk);
    check("pad driven", 32'(pad_a), 32'h0);
    dir_a <= 1'b0;
    @(posedge ref_clk);
    check("pad released", 32'(pad_a), 32'h1);
    dir_a <= 1'b1;
    wr(OFF_CTRL_C, 32'h80);
    repeat (2) @(posedge ref_clk);
    check("ctc force", 32'(wave[0]), 32'h1);
    rd(OFF_COUNT, d);
    check("ctc no clear", d, 32'h0100);
    wr(OFF_CTRL_A, 32'h81);
    wr(OFF_CTRL_C, 32'h80);
    repeat (2) @(posedge ref_clk);
    check("pwm force", 32'(wave[0]), 32'h1);
    $display("done force");
  endtask

  task automatic test_modes;
    logic [3:0] md [7] = '{4'h0, 4'h4, 4'hc, 4'h1, 4'h9, 4'h5, 4'hf};
    logic       ea [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic       eb [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int k = 0; k < 7; k++)
    begin
      wr(OFF_CTRL_B, {27'h0, md[k][3:2], 3'h0});
      wr(OFF_CTRL_A, {24'h0, 6'h14, md[k][1:0]});
      repeat (2) @(posedge ref_clk);
      check("oe a toggle", 32'(oe[0]), 32'(ea[k]));
      check("oe b toggle", 32'(oe[1]), 32'(eb[k]));
    end
    $display("done modes");
  endtask

  task automatic test_capture;
    logic [7:0]  cb [8] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h58, 8'hc0, 8'hc0, 8'hc0};
    logic        lv [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic        ef [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [3:0]  ec [8] = '{4'h1, 4'h1, 4'h1, 4'h4, 4'h4, 4'h4, 4'h4, 4'h8};
    logic [31:0] d;
    wr(OFF_CTRL_A, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      wr(OFF_CTRL_B, {24'h0, cb[k]});
      wr(OFF_COUNT, 32'h0a01 + k);
      wr(OFF_FLAGS, 32'h1f);
      if (k == 6)
      begin
        model.cap_set(1'b1, 2);
        model.cap_set(1'b0, 2);
      end
      model.cap_set(lv[k], 12);
      rd(OFF_FLAGS, d);
      check("capture flag", (d >> FLG_CAP) & 32'h1, 32'(ef[k]));
      rd(OFF_CAPTURE, d);
      check("captured", d, 32'h0a00 | 32'(ec[k]));
    end
    $display("done capture");
  endtask

  task automatic test_overflow;
    logic [31:0] d;
    wr(OFF_CTRL_B, 32'h0);
    wr(OFF_COUNT, 32'hfff0);
    wr(OFF_FLAGS, 32'h1f);
    wr(OFF_CTRL_B, {29'h0, CS_DIV1});
    repeat (30) @(posedge ref_clk);
    wr(OFF_CTRL_B, 32'h0);
    rd(OFF_FLAGS, d);
    check("overflow flag", (d >> FLG_OVF) & 32'h1, 32'h1);
    $display("done overflow");
  endtask

  // Each run below spans exactly 42 ticks, from the start write to the stop write.
  task automatic test_fast;
    logic [31:0] d;
    wr(OFF_MATCH_A, 32'h0080);
    wr(OFF_COUNT, 32'h007e);
    wr(OFF_CTRL_A, 32'h81);
    wr(OFF_CTRL_B, {29'h1, CS_DIV1});
    repeat (40) @(posedge ref_clk);
    wr(OFF_CTRL_B, 32'h08);
    rd(OFF_COUNT, d);
    check("fast count", d, 32'h00a8);
    check("fast match clear", 32'(wave[0]), 32'h0);
    wr(OFF_COUNT, 32'h00fe);
    wr(OFF_FLAGS, 32'h1f);
    wr(OFF_CTRL_B, {29'h1, CS_DIV1});
    repeat (40) @(posedge ref_clk);
    wr(OFF_CTRL_B, 32'h08);
    rd(OFF_COUNT, d);
    check("fast wrap", d, 32'h0028);
    check("fast top set", 32'(wave[0]), 32'h1);
    rd(OFF_FLAGS, d);
    check("fast top flag", (d >> FLG_OVF) & 32'h1, 32'h1);
    $display("done fast");
  endtask

  task automatic test_dual;
    logic [31:0] d;
    wr(OFF_CTRL_A, 32'h01);
    wr(OFF_COUNT, 32'h00f0);
    wr(OFF_FLAGS, 32'h1f);
    wr(OFF_CTRL_B, {29'h0, CS_DIV1});
    repeat (40) @(posedge ref_clk);
    wr(OFF_CTRL_B, 32'h0);
    rd(OFF_COUNT, d);
    check("pc turn at top", d, 32'h00e4);
    rd(OFF_FLAGS, d);
    check("pc no top flag", (d >> FLG_OVF) & 32'h1, 32'h0);
    wr(OFF_COUNT, 32'h0002);
    wr(OFF_CTRL_B, {29'h0, CS_DIV1});
    repeat (40) @(posedge ref_clk);
    wr(OFF_CTRL_B, 32'h0);
    rd(OFF_COUNT, d);
    check("pc turn at bottom", d, 32'h0028);
    rd(OFF_FLAGS, d);
    check("pc bottom flag", (d >> FLG_OVF) & 32'h1, 32'h1);
    $display("done dual");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dir_a = 1'b1;
    error_cnt = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_regs;
    test_prescale;
    test_ext;
    test_force;
    test_modes;
    test_capture;
    test_overflow;
    test_fast;
    test_dual;
    stop_test;
  end

  // The slowest test needs about 3000 cycles; 40000 leaves a wide margin.
  initial
  begin
    #400000;
    error_cnt++;
    stop_test;
  end
endmodule // test_timer16_control_regs
`default_nettype wire
